//--- hw/mbl_pkg.sv
// constants and types shared by the boot leader election logic
package mbl_pkg;

  // identifier, vector, kind, shorthand and address widths
  localparam int ID_W = 4;
  localparam int VEC_W = 8;
  localparam int KIND_W = 3;
  localparam int SH_W = 2;
  localparam int ADDR_W = 32;

  // message encodings
  localparam logic [3:0] GEN_CODE = 4'h4;
  localparam logic [ID_W-1:0] ID_UNUSED = 4'hF;
  localparam logic [VEC_W-1:0] FINAL_VECTOR = 8'h10;
  localparam logic [KIND_W-1:0] KIND_FIXED = 3'h0;
  localparam logic [KIND_W-1:0] KIND_STARTUP = 3'h6;
  localparam logic [SH_W-1:0] SH_ALL_INCL_SELF = 2'h2;
  localparam logic [SH_W-1:0] SH_ALL_EXCL_SELF = 2'h3;

  // receive word layout: {accept_err, checksum_err, kind, vector}
  localparam int RX_W = VEC_W + KIND_W + 2;
  localparam int RX_VEC_LSB = 0;
  localparam int RX_KIND_LSB = VEC_W;
  localparam int RX_CHK_BIT = VEC_W + KIND_W;
  localparam int RX_ACC_BIT = VEC_W + KIND_W + 1;

  // transmit word layout: {shorthand, kind, vector}
  localparam int TX_W = VEC_W + KIND_W + SH_W;

  // fetch addresses
  localparam logic [ADDR_W-1:0] RESET_VECTOR_ADDR = 32'hFFFFFFF0;
  localparam logic [11:0] STARTUP_ADDR_PAD = 12'h000;

  // reset values
  localparam logic [ID_W-1:0] ID_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;

  // election and run states
  typedef enum logic [3:0] {
    ST_CAPTURE,
    ST_SELF_TEST,
    ST_SEND_ARB,
    ST_ARB_WAIT,
    ST_SEND_FINAL,
    ST_FINAL_WAIT,
    ST_WAIT_STARTUP,
    ST_RUN,
    ST_HALT,
    ST_SHUTDOWN
  } mbl_state_e;

endpackage

//--- hw/mbl_word_xing.sv
// toggle handshake carrying one word between two clock domains
`timescale 1ns/1ps

module mbl_word_xing #(
  parameter int W = 8
) (
  input wire logic i_src_clk,
  input wire logic i_dst_clk,
  input wire logic i_reset_n,
  input wire logic i_src_valid,
  output logic o_src_ready,
  input wire logic [W-1:0] i_src_data,
  output logic o_dst_valid,
  output logic [W-1:0] o_dst_data
);

  logic req_ff;
  logic [W-1:0] hold_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic seen_ff;
  logic valid_ff;
  logic [W-1:0] data_ff;

  ////////////////////////////////////////////////////////////////
  // source side: ready once the last word was acknowledged
  assign o_src_ready = (req_ff == ack_s2_ff);

  // source toggle and held word
  always_ff @(posedge i_src_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_ff <= 1'b0;
      hold_ff <= '0;
    end else if (i_src_valid && o_src_ready) begin
      req_ff <= ~req_ff;
      hold_ff <= i_src_data;
    end
  end

  // acknowledge synchroniser
  always_ff @(posedge i_src_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= seen_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // request synchroniser
  always_ff @(posedge i_dst_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
    end
  end

  // destination capture, held word is stable while toggle differs
  always_ff @(posedge i_dst_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_ff <= 1'b0;
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      valid_ff <= (req_s2_ff != seen_ff);
      if (req_s2_ff != seen_ff) begin
        seen_ff <= req_s2_ff;
        data_ff <= hold_ff;
      end
    end
  end

  assign o_dst_valid = valid_ff;
  assign o_dst_data = data_ff;

endmodule // mbl_word_xing

//--- hw/mbl_boot_leader.sv
// boot leader election and follower parking for one processor
`timescale 1ns/1ps

// Function
// - election runs only after reset; later init requests never re-elect.
// - init after election: leader restarts bootstrap, follower waits for startup message.
// - topology identifier captured into the identifier register before election.
// - after self test, broadcast one arbitration message to all including self.
// - arbitration vector is generation code 4 over the sender identifier.
// - arbitration messages are accepted strictly one at a time.
// - first arbitration message matching own identifier sets the leader flag.
// - first arbitration message not matching makes this processor a follower.
// - new leader broadcasts final boot message, vector 10, edge, fixed delivery.
// - final boot message accepted only after all follower arbitration messages; the code takes the first one seen in ST_FINAL_WAIT, uncounted.
// - once a leader exists, remaining arbitration messages are discarded.
// - only the leader acts on final message, fetching at FFFF FFF0H.
// - follower starts at 000V V000H from the startup message vector.
// - halted follower wakes only for init, nmi, smi; still snoops and stops clock.
// - serial bus errors reported as checksum or acceptance error.
// - a bus error during election shuts the processor down.
// - the processor takes part even if its self test failed.
// - supports 2 to 15 processors through a four-bit identifier.
module mbl_boot_leader (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bus_clk,
  input wire logic [mbl_pkg::ID_W-1:0] i_topology_id,
  input wire logic i_self_test_done,
  input wire logic i_self_test_pass,
  input wire logic i_init_req,
  input wire logic i_nmi_req,
  input wire logic i_smi_req,
  input wire logic i_halt_req,
  input wire logic i_snoop_req,
  input wire logic i_stop_clock,
  input wire logic i_bus_rx_valid,
  output logic o_bus_rx_ready,
  input wire logic [mbl_pkg::VEC_W-1:0] i_bus_rx_vector,
  input wire logic [mbl_pkg::KIND_W-1:0] i_bus_rx_kind,
  input wire logic i_bus_rx_checksum_err,
  input wire logic i_bus_rx_accept_err,
  output logic o_bus_tx_valid,
  output logic [mbl_pkg::VEC_W-1:0] o_bus_tx_vector,
  output logic [mbl_pkg::KIND_W-1:0] o_bus_tx_kind,
  output logic [mbl_pkg::SH_W-1:0] o_bus_tx_shorthand,
  input wire logic i_bus_tx_done,
  output logic [mbl_pkg::ID_W-1:0] o_local_id,
  output logic o_leader_flag,
  output logic o_elected,
  output logic o_protocol_active,
  output logic o_wait_startup,
  output logic o_halted,
  output logic o_shutdown,
  output logic o_self_test_failed,
  output logic o_fetch_start,
  output logic [mbl_pkg::ADDR_W-1:0] o_fetch_addr,
  output logic o_wake_nmi,
  output logic o_wake_smi,
  output logic o_snoop_ack,
  output logic o_stop_clock_grant,
  output logic o_err_checksum,
  output logic o_err_accept
);

  mbl_pkg::mbl_state_e state_ff;
  mbl_pkg::mbl_state_e nxt_state;
  logic [mbl_pkg::ID_W-1:0] id_ff;
  logic leader_ff;
  logic elected_ff;
  logic built_in_self_test_fail_ff;
  logic fetch_ff;
  logic [mbl_pkg::ADDR_W-1:0] fetch_addr_ff;
  logic wake_nmi_ff;
  logic wake_smi_ff;
  logic snoop_ack_ff;
  logic stop_s1_ff;
  logic stop_s2_ff;
  logic err_chk_ff;
  logic err_acc_ff;
  logic core_rx_valid;
  logic [mbl_pkg::RX_W-1:0] core_rx_word;
  logic core_tx_valid;
  logic core_tx_ready;
  logic [mbl_pkg::TX_W-1:0] core_tx_word;
  logic link_tx_pulse;
  logic [mbl_pkg::TX_W-1:0] link_tx_word;
  logic link_tx_busy_ff;
  logic [mbl_pkg::TX_W-1:0] link_tx_hold_ff;
  logic [mbl_pkg::VEC_W-1:0] rx_vec;
  logic [mbl_pkg::KIND_W-1:0] rx_kind;
  logic rx_err;
  logic rx_is_arb;
  logic rx_is_final;
  logic rx_is_startup;

  // arbitration vector from an identifier
  function automatic logic [mbl_pkg::VEC_W-1:0] arb_vector(
    input logic [mbl_pkg::ID_W-1:0] id
  );
    arb_vector = {mbl_pkg::GEN_CODE, id};
  endfunction

  // follower entry address from a startup vector
  function automatic logic [mbl_pkg::ADDR_W-1:0] startup_addr(
    input logic [mbl_pkg::VEC_W-1:0] vv
  );
    startup_addr = {mbl_pkg::STARTUP_ADDR_PAD, vv, mbl_pkg::STARTUP_ADDR_PAD};
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus clock side: incoming messages cross one at a time
  mbl_word_xing #(
    .W(mbl_pkg::RX_W)
  ) u_rx_xing (
    .i_src_clk(i_bus_clk),
    .i_dst_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_src_valid(i_bus_rx_valid),
    .o_src_ready(o_bus_rx_ready),
    .i_src_data({i_bus_rx_accept_err, i_bus_rx_checksum_err, i_bus_rx_kind, i_bus_rx_vector}),
    .o_dst_valid(core_rx_valid),
    .o_dst_data(core_rx_word)
  );

  // outgoing messages cross to the bus clock
  mbl_word_xing #(
    .W(mbl_pkg::TX_W)
  ) u_tx_xing (
    .i_src_clk(i_clk),
    .i_dst_clk(i_bus_clk),
    .i_reset_n(i_reset_n),
    .i_src_valid(core_tx_valid),
    .o_src_ready(core_tx_ready),
    .i_src_data(core_tx_word),
    .o_dst_valid(link_tx_pulse),
    .o_dst_data(link_tx_word)
  );

  // bus side transmit holding until the bus reports the message sent
  always_ff @(posedge i_bus_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_tx_busy_ff <= 1'b0;
      link_tx_hold_ff <= '0;
    end else if (link_tx_pulse) begin
      link_tx_busy_ff <= 1'b1;
      link_tx_hold_ff <= link_tx_word;
    end else if (i_bus_tx_done) begin
      link_tx_busy_ff <= 1'b0;
    end
  end

  assign o_bus_tx_valid = link_tx_busy_ff;
  assign o_bus_tx_vector = link_tx_hold_ff[mbl_pkg::VEC_W-1:0];
  assign o_bus_tx_kind = link_tx_hold_ff[mbl_pkg::VEC_W +: mbl_pkg::KIND_W];
  assign o_bus_tx_shorthand = link_tx_hold_ff[mbl_pkg::VEC_W+mbl_pkg::KIND_W +: mbl_pkg::SH_W];

  ////////////////////////////////////////////////////////////////
  // received message decode
  assign rx_vec = core_rx_word[mbl_pkg::RX_VEC_LSB +: mbl_pkg::VEC_W];
  assign rx_kind = core_rx_word[mbl_pkg::RX_KIND_LSB +: mbl_pkg::KIND_W];
  assign rx_err = core_rx_word[mbl_pkg::RX_CHK_BIT] | core_rx_word[mbl_pkg::RX_ACC_BIT];
  assign rx_is_arb = core_rx_valid && !rx_err && (rx_kind == mbl_pkg::KIND_FIXED)
    && (rx_vec[7:4] == mbl_pkg::GEN_CODE);
  assign rx_is_final = core_rx_valid && !rx_err && (rx_kind == mbl_pkg::KIND_FIXED)
    && (rx_vec == mbl_pkg::FINAL_VECTOR);
  assign rx_is_startup = core_rx_valid && !rx_err && (rx_kind == mbl_pkg::KIND_STARTUP);

  // message to send in the sending states
  always_comb begin
    core_tx_valid = 1'b0;
    core_tx_word = '0;
    if (state_ff == mbl_pkg::ST_SEND_ARB) begin
      core_tx_valid = 1'b1;
      core_tx_word = {mbl_pkg::SH_ALL_INCL_SELF, mbl_pkg::KIND_FIXED, arb_vector(id_ff)};
    end else if (state_ff == mbl_pkg::ST_SEND_FINAL) begin
      core_tx_valid = 1'b1;
      core_tx_word = {mbl_pkg::SH_ALL_INCL_SELF, mbl_pkg::KIND_FIXED, mbl_pkg::FINAL_VECTOR};
    end
  end

  ////////////////////////////////////////////////////////////////
  // election and run state sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mbl_pkg::ST_CAPTURE: nxt_state = mbl_pkg::ST_SELF_TEST;
      mbl_pkg::ST_SELF_TEST: begin
        if (i_self_test_done) begin
          nxt_state = mbl_pkg::ST_SEND_ARB;
        end
      end
      mbl_pkg::ST_SEND_ARB: begin
        if (core_tx_ready) begin
          nxt_state = mbl_pkg::ST_ARB_WAIT;
        end
      end
      mbl_pkg::ST_ARB_WAIT: begin
        if (rx_is_arb) begin
          if (rx_vec[3:0] == id_ff) begin
            nxt_state = mbl_pkg::ST_SEND_FINAL;
          end else begin
            nxt_state = mbl_pkg::ST_WAIT_STARTUP;
          end
        end
      end
      mbl_pkg::ST_SEND_FINAL: begin
        if (core_tx_ready) begin
          nxt_state = mbl_pkg::ST_FINAL_WAIT;
        end
      end
      mbl_pkg::ST_FINAL_WAIT: begin
        if (rx_is_final) begin
          nxt_state = mbl_pkg::ST_RUN;
        end
      end
      mbl_pkg::ST_WAIT_STARTUP: begin
        if (rx_is_startup) begin
          nxt_state = mbl_pkg::ST_RUN;
        end
      end
      mbl_pkg::ST_RUN: begin
        if (i_init_req) begin
          nxt_state = leader_ff ? mbl_pkg::ST_RUN : mbl_pkg::ST_WAIT_STARTUP;
        end else if (i_halt_req && !leader_ff) begin
          nxt_state = mbl_pkg::ST_HALT;
        end
      end
      mbl_pkg::ST_HALT: begin
        if (i_init_req) begin
          nxt_state = mbl_pkg::ST_WAIT_STARTUP;
        end else if (i_nmi_req || i_smi_req) begin
          nxt_state = mbl_pkg::ST_RUN;
        end
      end
      mbl_pkg::ST_SHUTDOWN: nxt_state = mbl_pkg::ST_SHUTDOWN;
      default: nxt_state = mbl_pkg::ST_SHUTDOWN;
    endcase
    // bus error while electing stops this processor
    if (core_rx_valid && rx_err && !elected_ff) begin
      nxt_state = mbl_pkg::ST_SHUTDOWN;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= mbl_pkg::ST_CAPTURE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // identifier register caught in the first cycle after release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      id_ff <= mbl_pkg::ID_RESET;
    end else if (state_ff == mbl_pkg::ST_CAPTURE) begin
      id_ff <= i_topology_id;
    end
  end

  // self test outcome, kept only for reporting
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      built_in_self_test_fail_ff <= 1'b0;
    end else if (state_ff == mbl_pkg::ST_SELF_TEST && i_self_test_done) begin
      built_in_self_test_fail_ff <= !i_self_test_pass;
    end
  end

  // leader flag and election done; later arbitration messages ignored
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      leader_ff <= 1'b0;
      elected_ff <= 1'b0;
    end else if (state_ff == mbl_pkg::ST_ARB_WAIT && rx_is_arb && !elected_ff) begin
      leader_ff <= (rx_vec[3:0] == id_ff);
      elected_ff <= 1'b1;
    end
  end

  // instruction fetch start and address
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fetch_ff <= 1'b0;
      fetch_addr_ff <= mbl_pkg::ADDR_RESET;
    end else begin
      fetch_ff <= 1'b0;
      if (state_ff == mbl_pkg::ST_FINAL_WAIT && rx_is_final) begin
        fetch_ff <= 1'b1;
        fetch_addr_ff <= mbl_pkg::RESET_VECTOR_ADDR;
      end else if (state_ff == mbl_pkg::ST_WAIT_STARTUP && rx_is_startup) begin
        fetch_ff <= 1'b1;
        fetch_addr_ff <= startup_addr(rx_vec);
      end else if (state_ff == mbl_pkg::ST_RUN && i_init_req && leader_ff) begin
        fetch_ff <= 1'b1;
        fetch_addr_ff <= mbl_pkg::RESET_VECTOR_ADDR;
      end
    end
  end

  // wake pulses for a halted follower
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_nmi_ff <= 1'b0;
      wake_smi_ff <= 1'b0;
    end else begin
      wake_nmi_ff <= (state_ff == mbl_pkg::ST_HALT) && !i_init_req && i_nmi_req;
      wake_smi_ff <= (state_ff == mbl_pkg::ST_HALT) && !i_init_req && i_smi_req;
    end
  end

  // snoops and stop clock are answered in every state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      snoop_ack_ff <= 1'b0;
      stop_s1_ff <= 1'b0;
      stop_s2_ff <= 1'b0;
    end else begin
      snoop_ack_ff <= i_snoop_req;
      stop_s1_ff <= i_stop_clock;
      stop_s2_ff <= stop_s1_ff;
    end
  end

  // sticky bus error flags, cleared only by reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_chk_ff <= 1'b0;
      err_acc_ff <= 1'b0;
    end else if (core_rx_valid) begin
      err_chk_ff <= err_chk_ff | core_rx_word[mbl_pkg::RX_CHK_BIT];
      err_acc_ff <= err_acc_ff | core_rx_word[mbl_pkg::RX_ACC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // status outputs
  assign o_local_id = id_ff;
  assign o_leader_flag = leader_ff;
  assign o_elected = elected_ff;
  assign o_protocol_active = (state_ff != mbl_pkg::ST_RUN) && (state_ff != mbl_pkg::ST_HALT)
    && (state_ff != mbl_pkg::ST_SHUTDOWN);
  assign o_wait_startup = (state_ff == mbl_pkg::ST_WAIT_STARTUP);
  assign o_halted = (state_ff == mbl_pkg::ST_HALT);
  assign o_shutdown = (state_ff == mbl_pkg::ST_SHUTDOWN);
  assign o_self_test_failed = built_in_self_test_fail_ff;
  assign o_fetch_start = fetch_ff;
  assign o_fetch_addr = fetch_addr_ff;
  assign o_wake_nmi = wake_nmi_ff;
  assign o_wake_smi = wake_smi_ff;
  assign o_snoop_ack = snoop_ack_ff;
  assign o_stop_clock_grant = stop_s2_ff;
  assign o_err_checksum = err_chk_ff;
  assign o_err_accept = err_acc_ff;

endmodule // mbl_boot_leader

//--- verif/mbl_boot_leader_checker.sv
// assertions on the boot leader election ports
`timescale 1ns/1ps

module mbl_boot_leader_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bus_clk,
  input wire logic i_stop_clock,
  input wire logic i_bus_rx_valid,
  input wire logic o_bus_rx_ready,
  input wire logic o_bus_tx_valid,
  input wire logic [mbl_pkg::VEC_W-1:0] o_bus_tx_vector,
  input wire logic [mbl_pkg::KIND_W-1:0] o_bus_tx_kind,
  input wire logic [mbl_pkg::SH_W-1:0] o_bus_tx_shorthand,
  input wire logic i_bus_tx_done,
  input wire logic [mbl_pkg::ID_W-1:0] o_local_id,
  input wire logic o_leader_flag,
  input wire logic o_elected,
  input wire logic o_protocol_active,
  input wire logic o_halted,
  input wire logic o_shutdown,
  input wire logic o_fetch_start,
  input wire logic [mbl_pkg::ADDR_W-1:0] o_fetch_addr,
  input wire logic o_wake_nmi,
  input wire logic o_wake_smi,
  input wire logic o_stop_clock_grant
);
  ////////////////////////////////////////////////////////////////////////////////
  // multi-step behaviours
  sequence rx_take_s;
    i_bus_rx_valid && o_bus_rx_ready;
  endsequence
  sequence stop_held_s;
    i_stop_clock [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // bus clock side
  rx_one_a: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
    rx_take_s |=> !o_bus_rx_ready) else $error("ready high after a take");
  tx_arb_a: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
    o_bus_tx_valid && o_bus_tx_vector != mbl_pkg::FINAL_VECTOR |->
    o_bus_tx_vector == {mbl_pkg::GEN_CODE, o_local_id} && o_bus_tx_kind == mbl_pkg::KIND_FIXED
    && o_bus_tx_shorthand == mbl_pkg::SH_ALL_INCL_SELF) else $error("bad arbitration message");
  tx_final_a: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
    o_bus_tx_valid && o_bus_tx_vector == mbl_pkg::FINAL_VECTOR |-> o_leader_flag
    && o_bus_tx_kind == mbl_pkg::KIND_FIXED && o_bus_tx_shorthand == mbl_pkg::SH_ALL_INCL_SELF)
    else $error("bad final message");
  tx_hold_a: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
    o_bus_tx_valid && !i_bus_tx_done |=> o_bus_tx_valid && $stable(o_bus_tx_vector))
    else $error("message dropped before done");
  tx_once_a: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
    i_bus_tx_done |=> !o_bus_tx_valid) else $error("message repeated after done");
  ////////////////////////////////////////////////////////////////////////////////
  // core clock side
  leader_fetch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_fetch_start && o_leader_flag |-> o_fetch_addr == mbl_pkg::RESET_VECTOR_ADDR)
    else $error("leader fetch address wrong");
  follow_fetch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_fetch_start && !o_leader_flag |-> o_fetch_addr[31:20] == 12'h000
    && o_fetch_addr[11:0] == 12'h000) else $error("follower fetch address wrong");
  shut_stays_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_shutdown |=> o_shutdown && !o_fetch_start) else $error("left shutdown");
  role_fixed_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(o_elected) |-> o_elected && $stable(o_leader_flag)) else $error("role changed");
  leader_rise_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_leader_flag) |-> o_elected && o_protocol_active) else $error("late leader flag");
  stop_grant_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stop_held_s |-> o_stop_clock_grant) else $error("stop clock not granted");
  wake_halt_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_wake_nmi || o_wake_smi |-> $past(o_halted) && !o_halted) else $error("bad wake");
endmodule // mbl_boot_leader_checker

bind mbl_boot_leader mbl_boot_leader_checker mbl_boot_leader_checker_inst (.*);

//--- verif/mbl_peer_model.sv
// peer controllers on the shared interrupt bus
`timescale 1ns/1ps

module mbl_peer_model (
  input wire logic i_bus_clk,
  input wire logic i_reset_n,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [mbl_pkg::VEC_W-1:0] i_tx_vector,
  output logic o_rx_valid,
  output logic [mbl_pkg::RX_W-1:0] o_rx_word,
  output logic o_tx_done
);
  logic [mbl_pkg::RX_W-1:0] rxq[$];
  logic [mbl_pkg::VEC_W-1:0] txq[$];
  int wait_ff;
  logic slow_ff;

  task automatic offer(input logic [mbl_pkg::RX_W-1:0] w);
    rxq.push_back(w);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one message at a time, held until taken, then scrambled
  always @(posedge i_bus_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_valid <= 1'h0;
      o_rx_word <= '0;
    end else if (o_rx_valid && i_rx_ready) begin
      o_rx_valid <= 1'h0;
      o_rx_word <= ~o_rx_word;
      void'(rxq.pop_front());
    end else if (!o_rx_valid && rxq.size() > 0) begin
      o_rx_valid <= 1'h1;
      o_rx_word <= rxq[0];
    end
  end

  // sends each broadcast, promptly and slowly by turns, logging it
  always @(posedge i_bus_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_done <= 1'h0;
      wait_ff <= 0;
      slow_ff <= 1'h0;
    end else if (o_tx_done) begin
      o_tx_done <= 1'h0;
    end else if (i_tx_valid) begin
      if (wait_ff == (slow_ff ? 3 : 0)) begin
        o_tx_done <= 1'h1;
        txq.push_back(i_tx_vector);
        wait_ff <= 0;
        slow_ff <= !slow_ff;
      end else begin
        wait_ff <= wait_ff + 1;
      end
    end
  end
endmodule // mbl_peer_model

//--- verif/testbench.sv
// self-checking bench for the boot leader election block
`timescale 1ns/1ps

module testbench;
  logic i_clk = 1'h0;
  logic i_bus_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [3:0] i_topology_id = 4'h0;
  logic i_self_test_done = 1'h0, i_self_test_pass = 1'h0, i_init_req = 1'h0;
  logic i_nmi_req = 1'h0, i_smi_req = 1'h0, i_halt_req = 1'h0;
  logic i_snoop_req = 1'h0, i_stop_clock = 1'h0;
  logic i_bus_rx_valid, i_bus_tx_done, o_bus_rx_ready, o_bus_tx_valid, o_leader_flag;
  logic o_elected, o_protocol_active, o_wait_startup, o_halted, o_shutdown;
  logic o_self_test_failed, o_fetch_start, o_wake_nmi, o_wake_smi, o_snoop_ack;
  logic o_stop_clock_grant, o_err_checksum, o_err_accept;
  logic i_bus_rx_checksum_err, i_bus_rx_accept_err;
  logic [7:0] i_bus_rx_vector, o_bus_tx_vector;
  logic [2:0] i_bus_rx_kind, o_bus_tx_kind;
  logic [1:0] o_bus_tx_shorthand;
  logic [3:0] o_local_id;
  logic [31:0] o_fetch_addr;
  logic [12:0] rx_word;
  int n_errors = 0, total_checks = 0, fetch_cnt = 0, wake_cnt = 0;

  assign {i_bus_rx_accept_err, i_bus_rx_checksum_err, i_bus_rx_kind, i_bus_rx_vector} = rx_word;
  mbl_boot_leader mbl_boot_leader_inst (.*);
  mbl_peer_model mbl_peer_model_inst (.i_bus_clk(i_bus_clk), .i_reset_n(i_reset_n),
    .i_rx_ready(o_bus_rx_ready), .i_tx_valid(o_bus_tx_valid), .i_tx_vector(o_bus_tx_vector),
    .o_rx_valid(i_bus_rx_valid), .o_rx_word(rx_word), .o_tx_done(i_bus_tx_done));

  // core clock and free-running bus clock
  always #10 i_clk = ~i_clk;
  always #62.5 i_bus_clk = ~i_bus_clk;

  // count one-cycle pulses
  always @(posedge i_clk) begin
    if (o_fetch_start === 1'h1) fetch_cnt++;
    if ((o_wake_nmi | o_wake_smi) === 1'h1) wake_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic timeout();
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(3);
  endtask

  // interrupt inputs stay quiet while the election runs
  task automatic do_reset(input logic [3:0] id, input logic pass);
    i_reset_n = 1'h0;
    i_topology_id = id;
    i_self_test_pass = pass;
    repeat (3) @(posedge i_bus_clk);
    mbl_peer_model_inst.txq.delete();
    mbl_peer_model_inst.rxq.delete();
    chk(o_leader_flag, 32'h0);
    tick(1);
    i_reset_n = 1'h1;
    fetch_cnt = 0;
    wake_cnt = 0;
    tick(2);
    chk(o_local_id, id);
    pulse(i_self_test_done);
  endtask

  task automatic send(input logic [12:0] w);
    int k;
    mbl_peer_model_inst.offer(w);
    for (k = 0; k < 300 && !(mbl_peer_model_inst.rxq.size() == 0 && o_bus_rx_ready
      && !i_bus_rx_valid); k++) tick(1);
    if (k == 300) timeout();
    tick(4);
  endtask

  task automatic expect_tx(input logic [7:0] v);
    int k;
    for (k = 0; k < 300 && mbl_peer_model_inst.txq.size() == 0; k++) tick(1);
    if (k == 300) timeout();
    chk(mbl_peer_model_inst.txq.pop_front(), v);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_leader();
    do_reset(4'h3, 1'h0);
    expect_tx(8'h43);
    chk(o_self_test_failed, 32'h1);
    send({2'h0, mbl_pkg::KIND_FIXED, 8'h43});
    chk(o_leader_flag, 32'h1);
    expect_tx(mbl_pkg::FINAL_VECTOR);
    send({2'h0, mbl_pkg::KIND_FIXED, 8'h45});
    chk(o_leader_flag, 32'h1);
    chk(fetch_cnt, 32'h0);
    send({2'h0, mbl_pkg::KIND_FIXED, mbl_pkg::FINAL_VECTOR});
    chk(fetch_cnt, 32'h1);
    chk(o_fetch_addr, mbl_pkg::RESET_VECTOR_ADDR);
    pulse(i_init_req);
    chk(fetch_cnt, 32'h2);
    chk({o_leader_flag, o_protocol_active}, 32'h2);
    // leave room for a stray arbitration message to cross to the bus
    tick(60);
    chk(mbl_peer_model_inst.txq.size(), 32'h0);
    $display("leader test done");
  endtask

  task automatic t_follower();
    do_reset(4'h2, 1'h1);
    expect_tx(8'h42);
    chk(o_self_test_failed, 32'h0);
    send({2'h0, mbl_pkg::KIND_FIXED, 8'h45});
    chk({o_elected, o_leader_flag, o_wait_startup}, 32'h5);
    send({2'h0, mbl_pkg::KIND_FIXED, 8'h42});
    chk(o_leader_flag, 32'h0);
    send({2'h0, mbl_pkg::KIND_FIXED, mbl_pkg::FINAL_VECTOR});
    chk(fetch_cnt, 32'h0);
    chk(mbl_peer_model_inst.txq.size(), 32'h0);
    send({2'h0, mbl_pkg::KIND_STARTUP, 8'hA5});
    chk(o_fetch_addr, 32'h000A5000);
    pulse(i_halt_req);
    chk(o_halted, 32'h1);
    i_snoop_req = 1'h1;
    i_stop_clock = 1'h1;
    tick(4);
    chk({o_snoop_ack, o_stop_clock_grant, o_halted}, 32'h7);
    i_snoop_req = 1'h0;
    i_stop_clock = 1'h0;
    pulse(i_nmi_req);
    chk({wake_cnt[1:0], o_halted}, 32'h2);
    pulse(i_halt_req);
    pulse(i_smi_req);
    chk({wake_cnt[1:0], o_halted}, 32'h4);
    pulse(i_halt_req);
    pulse(i_init_req);
    chk(o_wait_startup, 32'h1);
    send({2'h0, mbl_pkg::KIND_STARTUP, 8'h01});
    chk(fetch_cnt, 32'h2);
    chk(o_fetch_addr, 32'h00001000);
    pulse(i_init_req);
    chk({o_wait_startup, o_leader_flag}, 32'h2);
    $display("follower test done");
  endtask

  task automatic t_error();
    for (int e = 0; e < 2; e++) begin
      do_reset(4'h1, 1'h1);
      send({e == 1, e == 0, mbl_pkg::KIND_FIXED, 8'h41});
      chk({o_shutdown, o_elected}, 32'h2);
      chk({o_err_accept, o_err_checksum}, e == 1 ? 32'h2 : 32'h1);
    end
    $display("bus error test done");
  endtask

  initial begin
    t_leader();
    t_follower();
    t_error();
    tally_and_finish();
  end
endmodule // testbench
